// ---- hdl/rx_mode_ctrl.v ----
`timescale 1ns/1ns
`include "rx_mode_map.vh"

module rx_mode_ctrl (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    input  wire       rx_run,
    input  wire       startup_done,
    input  wire       wakeup_found,
    input  wire       wakeup_fail,
    output reg        rf_power_down,
    output reg        osc_low_precision,
    output reg        startup_req,
    output reg        config_write_ok,
    output reg        rx_init,
    output reg        cfg_b_sel,
    output reg  [1:0] modulation_type,
    output reg        mod_switch,
    output reg        pll_load,
    output reg  [1:0] pll_channel,
    output reg        search_start,
    output reg        hold_active,
    output reg        run_slave,
    output reg        run_self_polling
);

    localparam [3:0] ST_SLEEP    = 4'h0;
    localparam [3:0] ST_STARTUP  = 4'h1;
    localparam [3:0] ST_INIT     = 4'h2;
    localparam [3:0] ST_SLAVE    = 4'h3;
    localparam [3:0] ST_HOLD     = 4'h4;
    localparam [3:0] ST_IDLE     = 4'h5;
    localparam [3:0] ST_WAIT_PWR = 4'h6;
    localparam [3:0] ST_LOOP     = 4'h7;
    localparam [3:0] ST_MOD      = 4'h8;
    localparam [3:0] ST_CFG      = 4'h9;
    localparam [3:0] ST_SETTLE   = 4'ha;
    localparam [3:0] ST_SEARCH   = 4'hb;
    localparam [3:0] ST_STORE    = 4'hc;
    localparam [3:0] ST_COMPARE  = 4'hd;
    localparam [3:0] ST_INCR     = 4'he;
    localparam [3:0] ST_RUN_SP   = 4'hf;

    localparam [`SETTLE_W-1:0] SETTLE_LAST = `SETTLE_LAST_CYCLE;

    reg [7:0]           mode_main_q;
    reg [7:0]           mode_second_q;
    reg [7:0]           cfg_a_mod_q;
    reg [7:0]           cfg_b_mod_q;
    reg [1:0]           actual_channel_q;
    reg [3:0]           state_q;
    reg [3:0]           state_d;
    reg [1:0]           chan_q;
    reg [1:0]           chan_d;
    reg                 scan_b_q;
    reg                 scan_b_d;
    reg [`SETTLE_W-1:0] settle_q;
    reg [`SETTLE_W-1:0] settle_d;

    wire       op_self_poll  = mode_main_q[`BIT_OP_MODE_SEL];
    wire       slave_rx_en   = mode_main_q[`BIT_SLAVE_RX_EN];
    wire       dual_cfg_en   = mode_main_q[`BIT_DUAL_CFG_EN];
    wire       slave_cfg_sel = mode_main_q[`BIT_SLAVE_CFG_SEL];
    wire       hold_req      = mode_second_q[`BIT_HOLD];
    wire [1:0] count_a       = cfg_a_mod_q[`MSB_CHAN_COUNT:`LSB_CHAN_COUNT];
    wire [1:0] count_b       = cfg_b_mod_q[`MSB_CHAN_COUNT:`LSB_CHAN_COUNT];
    wire [1:0] count_cur     = scan_b_q ? count_b : count_a;
    wire       in_scan       = (state_q >= ST_IDLE);
    wire       want_sleep    = !op_self_poll && !slave_rx_en;

    // register writes; settings are taken whenever written, but only sleep and
    // hold give the state machine a defined restart with them
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_main_q   <= `RST_MODE_MAIN;
            mode_second_q <= `RST_MODE_SECOND;
            cfg_a_mod_q   <= `RST_CFG_MOD;
            cfg_b_mod_q   <= `RST_CFG_MOD;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `ADDR_MODE_MAIN:   mode_main_q   <= reg_wdata;
                `ADDR_MODE_SECOND: mode_second_q <= reg_wdata;
                `ADDR_CFG_A_MOD:   cfg_a_mod_q   <= reg_wdata;
                `ADDR_CFG_B_MOD:   cfg_b_mod_q   <= reg_wdata;
                default:           mode_main_q   <= mode_main_q;
            endcase
        end
    end

    // only the actual-channel register is readable; others read as zero
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= `RST_ACTUAL_CHANNEL;
        else if (reg_rd)
        begin
            case (reg_addr)
                `ADDR_ACTUAL_CHANNEL: reg_rdata <= {6'h00, actual_channel_q};
                default:              reg_rdata <= 8'h00;
            endcase
        end
    end

    // actual channel: counter value is the channel code 1..3
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            actual_channel_q <= `CHAN_NONE;
        else if (state_q == ST_LOOP && !scan_b_q)
            actual_channel_q <= `CHAN_NONE;
        else if (state_q == ST_STORE)
            actual_channel_q <= chan_q;
    end

    always @*
    begin
        state_d  = state_q;
        chan_d   = chan_q;
        scan_b_d = scan_b_q;
        settle_d = settle_q;
        case (state_q)
            ST_SLEEP:
            begin
                if (op_self_poll)
                    state_d = ST_IDLE;
                else if (slave_rx_en)
                    state_d = ST_STARTUP;
            end
            ST_STARTUP:
            begin
                if (op_self_poll || want_sleep)
                    state_d = ST_SLEEP;
                else if (startup_done)
                    state_d = ST_INIT;
            end
            ST_INIT:
                state_d = ST_SLAVE;
            ST_SLAVE:
            begin
                if (op_self_poll || want_sleep)
                    state_d = ST_SLEEP;
                else if (hold_req)
                    state_d = ST_HOLD;
            end
            ST_HOLD:
            begin
                if (op_self_poll || want_sleep)
                    state_d = ST_SLEEP;
                else if (!hold_req)
                    state_d = ST_INIT;
            end
            ST_IDLE:
            begin
                scan_b_d = 1'b0;
                if (rx_run)
                    state_d = ST_WAIT_PWR;
            end
            ST_WAIT_PWR:
            begin
                if (startup_done)
                    state_d = ST_LOOP;
            end
            ST_LOOP:
            begin
                chan_d  = `CHAN_FIRST;
                state_d = ST_MOD;
            end
            ST_MOD:
                state_d = ST_CFG;
            ST_CFG:
            begin
                settle_d = {`SETTLE_W{1'b0}};
                state_d  = ST_SETTLE;
            end
            ST_SETTLE:
            begin
                settle_d = settle_q + 1'b1;
                if (settle_q == SETTLE_LAST)
                    state_d = ST_SEARCH;
            end
            ST_SEARCH:
            begin
                if (wakeup_found)
                    state_d = ST_STORE;
                else if (wakeup_fail)
                    state_d = ST_COMPARE;
            end
            ST_STORE:
                state_d = ST_RUN_SP;
            ST_COMPARE:
            begin
                // a zero count is taken as one channel so the loop always ends
                if (chan_q >= count_cur)
                begin
                    if (dual_cfg_en && !scan_b_q)
                    begin
                        scan_b_d = 1'b1;
                        state_d  = ST_LOOP;
                    end
                    else
                        state_d = ST_IDLE;
                end
                else
                    state_d = ST_INCR;
            end
            ST_INCR:
            begin
                chan_d   = chan_q + 1'b1;
                settle_d = {`SETTLE_W{1'b0}};
                state_d  = ST_SETTLE;
            end
            ST_RUN_SP:
                state_d = ST_RUN_SP;
            default:
                state_d = ST_SLEEP;
        endcase
        // a self polling scan only ends by leaving self polling select
        if (in_scan && !op_self_poll)
            state_d = ST_SLEEP;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q  <= ST_SLEEP;
            chan_q   <= `CHAN_FIRST;
            scan_b_q <= 1'b0;
            settle_q <= {`SETTLE_W{1'b0}};
        end
        else
        begin
            state_q  <= state_d;
            chan_q   <= chan_d;
            scan_b_q <= scan_b_d;
            settle_q <= settle_d;
        end
    end

    // configuration for the next state: the select bit rules slave operation,
    // the scan pass rules self polling, so a single-config scan stays on a
    reg       use_b_d;
    reg [1:0] mod_type_d;

    always @*
    begin
        use_b_d    = scan_b_d;
        mod_type_d = cfg_a_mod_q[`MSB_MOD_TYPE:`LSB_MOD_TYPE];
        if (state_d < ST_IDLE)
            use_b_d = slave_cfg_sel;
        if (use_b_d)
            mod_type_d = cfg_b_mod_q[`MSB_MOD_TYPE:`LSB_MOD_TYPE];
    end

    // pulses mark entry to a state, so a long stay still gives only one
    wire enter_settle = (state_d == ST_SETTLE) && (state_q != ST_SETTLE);
    wire enter_search = (state_d == ST_SEARCH) && (state_q != ST_SEARCH);

    // outputs are registered from the next state so they line up with state_q
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rf_power_down     <= 1'b1;
            osc_low_precision <= 1'b1;
            startup_req       <= 1'b0;
            config_write_ok   <= 1'b1;
            cfg_b_sel         <= 1'b0;
            modulation_type   <= 2'h0;
            hold_active       <= 1'b0;
            run_slave         <= 1'b0;
            run_self_polling  <= 1'b0;
        end
        else
        begin
            rf_power_down     <= (state_d == ST_SLEEP) || (state_d == ST_IDLE);
            osc_low_precision <= (state_d == ST_SLEEP);
            startup_req       <= (state_d == ST_STARTUP) || (state_d == ST_WAIT_PWR);
            config_write_ok   <= (state_d == ST_SLEEP) || (state_d == ST_HOLD);
            cfg_b_sel         <= use_b_d;
            modulation_type   <= mod_type_d;
            hold_active       <= (state_d == ST_HOLD);
            run_slave         <= (state_d == ST_SLAVE);
            run_self_polling  <= (state_d == ST_RUN_SP);
        end
    end

    // strobes towards receiver and pll; slave run always loads the first channel
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_init           <= 1'b0;
            mod_switch        <= 1'b0;
            pll_load          <= 1'b0;
            pll_channel       <= `CHAN_FIRST;
            search_start      <= 1'b0;
        end
        else
        begin
            rx_init           <= (state_d == ST_INIT) || (state_d == ST_CFG);
            mod_switch        <= (state_d == ST_MOD);
            pll_load          <= (state_d == ST_INIT) || enter_settle;
            pll_channel       <= (state_d < ST_IDLE) ? `CHAN_FIRST : chan_d;
            search_start      <= enter_search;
        end
    end

endmodule // rx_mode_ctrl

// ---- hdl/rx_mode_map.vh ----
`ifndef RX_MODE_MAP_VH
`define RX_MODE_MAP_VH

// register offsets
`define ADDR_MODE_MAIN      8'h02
`define ADDR_MODE_SECOND    8'h03
`define ADDR_CFG_A_MOD      8'h21
`define ADDR_CFG_B_MOD      8'h42
`define ADDR_ACTUAL_CHANNEL 8'h0f

// reset values
`define RST_MODE_MAIN       8'h40
`define RST_MODE_SECOND     8'h00
`define RST_CFG_MOD         8'h04
`define RST_ACTUAL_CHANNEL  8'h00

// field positions
`define BIT_OP_MODE_SEL     0
`define BIT_SLAVE_RX_EN     1
`define BIT_DUAL_CFG_EN     2
`define BIT_SLAVE_CFG_SEL   3
`define BIT_HOLD            6
`define MSB_CHAN_COUNT      3
`define LSB_CHAN_COUNT      2
`define MSB_MOD_TYPE        1
`define LSB_MOD_TYPE        0

// channel codes
`define CHAN_NONE           2'h0
`define CHAN_FIRST          2'h1

// pll settle time: 40 us at a 10 ns clock is 4000 cycles, counted from zero
`define SETTLE_LAST_CYCLE   12'hf9f
`define SETTLE_W            12

`endif

// ---- bench/rx_mode_ctrl_asserts.sv ----
`timescale 1ns/1ns
module rx_mode_ctrl_asserts (
    input wire       clk,
    input wire       rst_n,
    input wire       rx_run,
    input wire       startup_done,
    input wire       wakeup_found,
    input wire       rf_power_down,
    input wire       osc_low_precision,
    input wire       startup_req,
    input wire       config_write_ok,
    input wire       rx_init,
    input wire       mod_switch,
    input wire       pll_load,
    input wire [1:0] pll_channel,
    input wire       search_start,
    input wire       hold_active,
    input wire       run_slave,
    input wire       run_self_polling
);
    reg [12:0] gap_q;
    reg        seen_q;
    // gap saturates so a stuck settle counter cannot wrap into the window
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            gap_q  <= 13'h0;
            seen_q <= 1'b0;
        end
        else
        begin
            gap_q  <= pll_load ? 13'h0 : (gap_q == 13'h1fff ? gap_q : gap_q + 13'h1);
            seen_q <= search_start ? 1'b0 : (seen_q | wakeup_found);
        end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_sleep_state: assert property (osc_low_precision |-> rf_power_down && config_write_ok
        && !run_slave && !run_self_polling && !hold_active) else $error("sleep outputs wrong");
    a_hold_write_ok: assert property (hold_active |-> config_write_ok) else $error("hold no cfg");
    a_hold_from_slave: assert property ($rose(hold_active) |-> $past(run_slave))
        else $error("hold outside slave");
    a_scan_leave_idle: assert property ($rose(startup_req) && !$past(osc_low_precision)
        |-> $past(rx_run)) else $error("idle left without run");
    a_wait_power_up: assert property ($fell(startup_req) && !osc_low_precision
        |-> $past(startup_done)) else $error("left wait early");
    a_mod_then_init: assert property (mod_switch |=> rx_init) else $error("no init");
    a_first_channel: assert property ($past(mod_switch) && rx_init
        |=> pll_load && pll_channel == 2'h1) else $error("channel 1 not loaded");
    a_settle_time: assert property (search_start |-> gap_q >= 13'hf96 && gap_q <= 13'hfaa)
        else $error("settle time wrong");
    a_wakeup_cause: assert property ($rose(run_self_polling) |-> seen_q)
        else $error("run without wakeup");
    a_slave_one_chan: assert property (run_slave |-> pll_channel == 2'h1 && !run_self_polling)
        else $error("slave channel wrong");
endmodule // rx_mode_ctrl_asserts
bind rx_mode_ctrl rx_mode_ctrl_asserts u_chk (.clk, .rst_n, .rx_run, .startup_done, .wakeup_found,
    .rf_power_down, .osc_low_precision, .startup_req, .config_write_ok, .rx_init, .mod_switch,
    .pll_load, .pll_channel, .search_start, .hold_active, .run_slave, .run_self_polling);

// ---- bench/rx_front_model.sv ----
`timescale 1ns/1ns
module rx_front_model (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       startup_req,
    input  wire       search_start,
    input  wire       clr,
    input  wire [7:0] mask,
    output reg        startup_done,
    output reg        wakeup_found,
    output reg        wakeup_fail
);
    reg [2:0] pu_q;
    reg [2:0] idx_q;
    reg [3:0] dly_q;
    // search verdicts come from mask, one bit per search, so a scan is scripted
    always @(posedge clk or negedge rst_n)
        if (!rst_n)
        begin
            pu_q         <= 3'h0;
            idx_q        <= 3'h0;
            dly_q        <= 4'h0;
            startup_done <= 1'b0;
            wakeup_found <= 1'b0;
            wakeup_fail  <= 1'b0;
        end
        else
        begin
            pu_q         <= startup_req ? (pu_q == 3'h7 ? pu_q : pu_q + 3'h1) : 3'h0;
            startup_done <= startup_req && pu_q == 3'h7;
            dly_q        <= search_start ? 4'h9 : (dly_q != 4'h0 ? dly_q - 4'h1 : 4'h0);
            wakeup_found <= dly_q == 4'h1 && mask[idx_q];
            wakeup_fail  <= dly_q == 4'h1 && !mask[idx_q];
            idx_q        <= clr ? 3'h0 : idx_q + {2'h0, dly_q == 4'h1};
        end
endmodule // rx_front_model

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`include "rx_mode_map.vh"
module testbench;
    reg        clk, rst_n, reg_wr, reg_rd, rx_run, clr;
    reg  [7:0] reg_addr, reg_wdata, mask, log_q, v;
    wire [7:0] reg_rdata;
    wire [1:0] modulation_type, pll_channel;
    wire       startup_done, wakeup_found, wakeup_fail, rf_power_down, osc_low_precision;
    wire       startup_req, config_write_ok, rx_init, cfg_b_sel, mod_switch, pll_load;
    wire       search_start, hold_active, run_slave, run_self_polling;
    integer    err_total, cmp_count;
    wire [7:0] st = {startup_req, rf_power_down, osc_low_precision, config_write_ok,
                     hold_active, run_slave, run_self_polling, cfg_b_sel};
    rx_mode_ctrl dut (.clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .rx_run,
        .startup_done, .wakeup_found, .wakeup_fail, .rf_power_down, .osc_low_precision,
        .startup_req, .config_write_ok, .rx_init, .cfg_b_sel, .modulation_type, .mod_switch,
        .pll_load, .pll_channel, .search_start, .hold_active, .run_slave, .run_self_polling);
    rx_front_model peer (.clk, .rst_n, .startup_req, .search_start, .clr, .mask,
        .startup_done, .wakeup_found, .wakeup_fail);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
        if (clr)
            log_q <= 8'h00;
        else if (pll_load === 1'b1)
            log_q <= {log_q[5:0], pll_channel};
    task chk(input [7:0] seen, input [7:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    end
    endtask
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(posedge clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1 reg_wr = 1'b0;
    end
    endtask
    task rd(input [7:0] a);
    begin
        @(posedge clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_rd = 1'b0;
        v = reg_rdata;
    end
    endtask
    task wt(input [7:0] m);
    integer n;
    begin
        for (n = 0; n < 20000 && (st & m) !== m; n = n + 1)
            @(posedge clk) #1;
        if (n == 20000)
        begin
            err_total = err_total + 1;
            $display("Error at %0t: wait for state %h timed out", $time, m);
        end
    end
    endtask
    task scan(input [7:0] mn, input [7:0] am, input [7:0] bm, input [7:0] msk);
    begin
        wr(`ADDR_MODE_MAIN, 8'h00);
        wr(`ADDR_CFG_A_MOD, am);
        wr(`ADDR_CFG_B_MOD, bm);
        mask = msk;
        clr = 1'b1;
        wr(`ADDR_MODE_MAIN, mn);
        clr = 1'b0;
        rx_run = 1'b1;
        wt(8'h80);
        rx_run = 1'b0;
    end
    endtask
    task t_reset;
    begin
        chk(st, 8'h70);
        rd(`ADDR_ACTUAL_CHANNEL);
        chk(v, `RST_ACTUAL_CHANNEL);
        wr(`ADDR_ACTUAL_CHANNEL, 8'hff);
        rd(`ADDR_ACTUAL_CHANNEL);
        chk(v, 8'h00);
        rd(8'h55);
        chk(v, 8'h00);
        wr(`ADDR_MODE_SECOND, 8'h40);
        chk(st, 8'h70);
        wr(`ADDR_MODE_SECOND, 8'h00);
    end
    endtask
    task t_slave;
    begin
        wr(`ADDR_MODE_MAIN, 8'h02);
        wt(8'h04);
        chk(st, 8'h04);
        chk({6'h0, pll_channel}, 8'h01);
        wr(`ADDR_MODE_SECOND, 8'h40);
        wt(8'h08);
        chk(st, 8'h18);
        wr(`ADDR_MODE_MAIN, 8'h0a);
        repeat (4000) @(posedge clk);
        wr(`ADDR_MODE_SECOND, 8'h00);
        wt(8'h05);
        chk(st, 8'h05);
        wr(`ADDR_MODE_MAIN, 8'h00);
        wt(8'h70);
        chk(st & 8'hfe, 8'h70);
    end
    endtask
    task t_found1;
    begin
        scan(8'h01, 8'h05, 8'h0a, 8'h01);
        wt(8'h02);
        chk(st, 8'h02);
        chk({6'h0, modulation_type}, 8'h01);
        chk(log_q, 8'h01);
        rd(`ADDR_ACTUAL_CHANNEL);
        chk(v, 8'h01);
    end
    endtask
    task t_three;
    begin
        scan(8'h01, 8'h0c, 8'h04, 8'h04);
        wt(8'h02);
        chk(log_q, 8'h1b);
        rd(`ADDR_ACTUAL_CHANNEL);
        chk(v, 8'h03);
    end
    endtask
    task t_dual;
    begin
        scan(8'h05, 8'h04, 8'h0a, 8'h04);
        wt(8'h03);
        chk(st, 8'h03);
        chk({6'h0, modulation_type}, 8'h02);
        chk(log_q, 8'h16);
        rd(`ADDR_ACTUAL_CHANNEL);
        chk(v, 8'h02);
    end
    endtask
    task t_exhaust;
    begin
        scan(8'h01, 8'h04, 8'h0a, 8'h00);
        wt(8'h40);
        repeat (50) @(posedge clk);
        #1 chk(st, 8'h40);
        rd(`ADDR_ACTUAL_CHANNEL);
        chk(v, 8'h00);
    end
    endtask
    task end_of_test;
    begin
        $display("mismatches %0d, comparisons %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    initial
    begin
        #600000;
        err_total = err_total + 1;
        end_of_test;
    end
    initial
    begin
        {rst_n, reg_wr, reg_rd, rx_run, clr} = 5'h0;
        {reg_addr, reg_wdata, mask} = 24'h0;
        err_total = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        t_reset;
        t_slave;
        t_found1;
        t_three;
        t_dual;
        t_exhaust;
        end_of_test;
    end
endmodule // testbench
